// ==== rtl/ctp_pkg.sv ====
// Package for the core timer and power control register group.
// Assumes a single 25 MHz system clock and a byte-wide register port.
`default_nettype none
package ctp_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_SCRATCH = 8'h80;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_DPL = 8'h82;
    localparam logic [7:0] ADDR_DPH = 8'h83;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_TIMER_INTERRUPT_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hc0;
    localparam logic [7:0] ADDR_IRQ_EN = 8'hc1;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'hc2;
    // ==========================================
    // Reset values
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_DP = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ==========================================
    // Power control fields
    localparam int PC_BAUD = 7;
    localparam int PC_FLAG_A = 3;
    localparam int PC_FLAG_B = 2;
    localparam int PC_PD = 1;
    localparam int PC_IDL = 0;
    localparam logic [7:0] PC_MASK = 8'h8f;
    // ==========================================
    // Timer/interrupt control fields
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;
    // ==========================================
    // Event status bits: 0 tmr0 ovf, 1 tmr1 ovf, 2 ext0, 3 ext1
    localparam int NUM_EV = 4;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ctp_bus_s;
    typedef struct packed {
        logic tmr1;
        logic tmr0;
        logic ext1;
        logic ext0;
    } ctp_ack_s;
endpackage
`default_nettype wire

// ==== rtl/ctp_regs.sv ====
// Core timer and power control register group.
// Assumes the core strobes one register access per cycle and pulses the
// vector acknowledges; the ext pins are asynchronous and are synchronised here.
// Notes on behaviour
// - Scratch byte at 80h is plain read/write storage, resets zero.
// - Data pointer low and high bytes at 82h/83h, read/write, reset zero.
// - Power control bit 7 doubles first serial port baud; resets zero.
// - Power control bits 3 and 2 are spare flags, no hardware effect.
// - Writing one to powerdown request bit enters stop mode; resets zero.
// - Writing one to idle request bit enters idle mode unless the powerdown bit is also set; resets zero.
// - Timer1 overflow flag set on overflow, cleared on vector acknowledge.
// - Timer1 run bit enables timer1 counting; resets zero.
// - Timer0 overflow flag set on overflow, cleared on vector acknowledge.
// - Timer0 run bit enables timer0 counting; resets zero.
// - Ext1 edge flag set on ext1 falling edge, cleared on vector.
// - Ext1 trigger select: zero low level, one falling edge.
// - Ext0 edge flag set on ext0 falling edge, cleared on vector.
// - Ext0 trigger select: zero low level, one falling edge.
// - With pin gating, timer counts only while run bit and pin high.
`default_nettype none
module ctp_regs (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Timer events and gating options
    input wire logic i_timer0_overflow,
    input wire logic i_timer1_overflow,
    input wire logic i_timer0_pin_gating,
    input wire logic i_timer1_pin_gating,
    // Vector acknowledges from the core
    input wire logic i_ack_timer0,
    input wire logic i_ack_timer1,
    input wire logic i_ack_ext0,
    input wire logic i_ack_ext1,
    // External interrupt pins
    input wire logic i_ext0_pin,
    input wire logic i_ext1_pin,
    // Core-facing state
    output logic [7:0] o_stack_pointer,
    output logic [15:0] o_data_pointer,
    output logic o_baud_doubler,
    output logic o_stop_mode,
    output logic o_idle_mode,
    output logic o_timer0_count_en,
    output logic o_timer1_count_en,
    output logic o_ext0_request,
    output logic o_ext1_request,
    output logic o_timer0_request,
    output logic o_timer1_request,
    // Interrupt
    output logic o_irq
);
    // ==========================================
    // Bus decode
    // Bundles keep the port and the acknowledges together as one carrier
    ctp_pkg::ctp_bus_s bus;
    ctp_pkg::ctp_ack_s ack;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign ack = '{tmr1: i_ack_timer1, tmr0: i_ack_timer0,
                   ext1: i_ack_ext1, ext0: i_ack_ext0};

    function automatic logic wr_hit(input ctp_pkg::ctp_bus_s b, input logic [7:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    logic [7:0] scratch_q, sp_q, dpl_q, dph_q, power_control_q, timer_interrupt_control_q;
    logic [ctp_pkg::NUM_EV-1:0] stat_q, en_q;
    logic [7:0] rdata_q;

    // ==========================================
    // Pin synchronisers
    // Flops reset high, the idle level of the pins, so leaving reset
    // shows no false falling edge.
    logic [1:0] pin_raw;
    wire [1:0] pin_lvl;
    wire [1:0] pin_fall;
    assign pin_raw = {i_ext1_pin, i_ext0_pin};
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pin
            logic [1:0] sync_q;
            logic prev_q;
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    sync_q <= 2'h3;
                    prev_q <= 1'b1;
                end else begin
                    sync_q <= {sync_q[0], pin_raw[p]};
                    prev_q <= sync_q[1];
                end
            end
            assign pin_lvl[p] = sync_q[1];
            assign pin_fall[p] = prev_q && !sync_q[1];
        end
    endgenerate

    logic ext0_lvl, ext1_lvl;
    logic ext0_fall, ext1_fall;
    assign ext0_lvl = pin_lvl[0];
    assign ext1_lvl = pin_lvl[1];
    assign ext0_fall = pin_fall[0];
    assign ext1_fall = pin_fall[1];

    // ==========================================
    // Plain storage bytes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            scratch_q <= ctp_pkg::RST_SCRATCH;
        end else if (wr_hit(bus, ctp_pkg::ADDR_SCRATCH)) begin
            scratch_q <= bus.wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sp_q <= ctp_pkg::RST_SP;
        end else if (wr_hit(bus, ctp_pkg::ADDR_SP)) begin
            sp_q <= bus.wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            dpl_q <= ctp_pkg::RST_DP;
            dph_q <= ctp_pkg::RST_DP;
        end else begin
            if (wr_hit(bus, ctp_pkg::ADDR_DPL)) begin
                dpl_q <= bus.wdata;
            end
            if (wr_hit(bus, ctp_pkg::ADDR_DPH)) begin
                dph_q <= bus.wdata;
            end
        end
    end

    // ==========================================
    // Power control
    // Stop and idle requests stay set until software or the wake logic
    // rewrites them; wake-up lives outside this block.
    logic pc_wr;
    logic [7:0] power_control_d;
    assign pc_wr = wr_hit(bus, ctp_pkg::ADDR_POWER_CONTROL);
    always_comb begin
        power_control_d = power_control_q;
        if (pc_wr) begin
            power_control_d = bus.wdata & ctp_pkg::PC_MASK;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            power_control_q <= ctp_pkg::RST_BYTE;
        end else begin
            power_control_q <= power_control_d;
        end
    end

    assign o_baud_doubler = power_control_q[ctp_pkg::PC_BAUD];

    // ==========================================
    // Power mode
    // Mode moves on the same edge as the request bits, so the two never
    // disagree; stop wins when both requests are written together.
    // One-hot codes written out; no other value is reachable.
    typedef enum logic [2:0] {
        PM_RUN = 3'b001,
        PM_IDLE = 3'b010,
        PM_STOP = 3'b100
    } ctp_pmode_e;
    ctp_pmode_e pmode_q;
    ctp_pmode_e pmode_d;
    logic stop_mode;
    logic idle_mode;

    function automatic ctp_pmode_e pmode_of(input logic [7:0] pc);
        if (pc[ctp_pkg::PC_PD]) begin
            pmode_of = PM_STOP;
        end else if (pc[ctp_pkg::PC_IDL]) begin
            pmode_of = PM_IDLE;
        end else begin
            pmode_of = PM_RUN;
        end
    endfunction

    always_comb begin
        pmode_d = pmode_q;
        if (pc_wr) begin
            pmode_d = pmode_of(power_control_d);
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pmode_q <= PM_RUN;
        end else begin
            pmode_q <= pmode_d;
        end
    end

    // Unknown codes decode as stop: a corrupted mode must not let the core run
    always_comb begin
        stop_mode = 1'b0;
        idle_mode = 1'b0;
        case (pmode_q)
            PM_RUN: begin
                stop_mode = 1'b0;
            end
            PM_IDLE: begin
                idle_mode = 1'b1;
            end
            PM_STOP: begin
                stop_mode = 1'b1;
            end
            default: begin
                stop_mode = 1'b1;
            end
        endcase
    end
    assign o_stop_mode = stop_mode;
    assign o_idle_mode = idle_mode;

    // ==========================================
    // Timer/interrupt control
    logic tc_wr;
    logic [7:0] timer_interrupt_control_d;
    assign tc_wr = wr_hit(bus, ctp_pkg::ADDR_TIMER_INTERRUPT_CONTROL);
    always_comb begin
        timer_interrupt_control_d = tc_wr ? bus.wdata : timer_interrupt_control_q;
        // Hardware set beats both software clear and vector clear
        if (ack.tmr1) begin
            timer_interrupt_control_d[ctp_pkg::TC_TF1] = 1'b0;
        end
        if (i_timer1_overflow) begin
            timer_interrupt_control_d[ctp_pkg::TC_TF1] = 1'b1;
        end
        if (ack.tmr0) begin
            timer_interrupt_control_d[ctp_pkg::TC_TF0] = 1'b0;
        end
        if (i_timer0_overflow) begin
            timer_interrupt_control_d[ctp_pkg::TC_TF0] = 1'b1;
        end
        if (ack.ext1) begin
            timer_interrupt_control_d[ctp_pkg::TC_IE1] = 1'b0;
        end
        if (timer_interrupt_control_q[ctp_pkg::TC_IT1] && ext1_fall) begin
            timer_interrupt_control_d[ctp_pkg::TC_IE1] = 1'b1;
        end
        if (ack.ext0) begin
            timer_interrupt_control_d[ctp_pkg::TC_IE0] = 1'b0;
        end
        if (timer_interrupt_control_q[ctp_pkg::TC_IT0] && ext0_fall) begin
            timer_interrupt_control_d[ctp_pkg::TC_IE0] = 1'b1;
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            timer_interrupt_control_q <= ctp_pkg::RST_BYTE;
        end else begin
            timer_interrupt_control_q <= timer_interrupt_control_d;
        end
    end

    // Edge flag only counts in edge mode; level mode follows the pin
    assign o_ext1_request = timer_interrupt_control_q[ctp_pkg::TC_IT1] ? timer_interrupt_control_q[ctp_pkg::TC_IE1]
                                                    : !ext1_lvl;
    assign o_ext0_request = timer_interrupt_control_q[ctp_pkg::TC_IT0] ? timer_interrupt_control_q[ctp_pkg::TC_IE0]
                                                    : !ext0_lvl;
    // Timer requests are the overflow flags themselves
    assign o_timer1_request = timer_interrupt_control_q[ctp_pkg::TC_TF1];
    assign o_timer0_request = timer_interrupt_control_q[ctp_pkg::TC_TF0];

    // Gating sees the synchronised pin, two cycles behind the pin itself
    assign o_timer1_count_en = timer_interrupt_control_q[ctp_pkg::TC_TR1]
                               && (!i_timer1_pin_gating || ext1_lvl);
    assign o_timer0_count_en = timer_interrupt_control_q[ctp_pkg::TC_TR0]
                               && (!i_timer0_pin_gating || ext0_lvl);

    // ==========================================
    // Interrupt status, enable and clear
    // Status bits are sticky; an event in the clear cycle keeps its bit
    logic [ctp_pkg::NUM_EV-1:0] ev;
    logic [ctp_pkg::NUM_EV-1:0] clr;
    assign ev = {timer_interrupt_control_d[ctp_pkg::TC_IE1] & ~timer_interrupt_control_q[ctp_pkg::TC_IE1],
                 timer_interrupt_control_d[ctp_pkg::TC_IE0] & ~timer_interrupt_control_q[ctp_pkg::TC_IE0],
                 i_timer1_overflow, i_timer0_overflow};
    assign clr = wr_hit(bus, ctp_pkg::ADDR_IRQ_CLR) ? bus.wdata[ctp_pkg::NUM_EV-1:0]
                                                    : '0;
    genvar g;
    generate
        for (g = 0; g < ctp_pkg::NUM_EV; g++) begin : g_stat
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    stat_q[g] <= 1'b0;
                end else if (ev[g]) begin
                    stat_q[g] <= 1'b1;
                end else if (clr[g]) begin
                    stat_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Enable bits gate only the shared line, never the flags
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            en_q <= '0;
        end else if (wr_hit(bus, ctp_pkg::ADDR_IRQ_EN)) begin
            en_q <= bus.wdata[ctp_pkg::NUM_EV-1:0];
        end
    end
    assign o_irq = |(stat_q & en_q);

    // ==========================================
    // Read data, valid the cycle after the strobe
    // Unmapped offsets read as zero so stray reads are harmless
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ctp_pkg::ADDR_SCRATCH: rdata_q <= scratch_q;
                ctp_pkg::ADDR_SP: rdata_q <= sp_q;
                ctp_pkg::ADDR_DPL: rdata_q <= dpl_q;
                ctp_pkg::ADDR_DPH: rdata_q <= dph_q;
                ctp_pkg::ADDR_POWER_CONTROL: rdata_q <= power_control_q;
                ctp_pkg::ADDR_TIMER_INTERRUPT_CONTROL: rdata_q <= timer_interrupt_control_q;
                ctp_pkg::ADDR_IRQ_STAT: rdata_q <= {4'h0, stat_q};
                ctp_pkg::ADDR_IRQ_EN: rdata_q <= {4'h0, en_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign o_rdata = rdata_q;
    assign o_stack_pointer = sp_q;
    assign o_data_pointer = {dph_q, dpl_q};
endmodule
`default_nettype wire

// ==== verification/ctp_core_model.sv ====
// Core model: vectors into a pending routine while the bench allows it.
// Assumes requests come straight from the register group outputs.
`default_nettype none
module ctp_core_model (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Vectoring control
    input wire logic i_take,
    input wire ctp_pkg::ctp_ack_s i_req,
    output ctp_pkg::ctp_ack_s o_ack
);
    // ==========================================
    // One-cycle acknowledge, then a gap so a flag can drop
    always_ff @(posedge i_clock) begin
        if (i_rst || o_ack != '0) begin
            o_ack <= '0;
        end else begin
            o_ack <= i_take ? i_req : '0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/ctp_regs_sva.sv ====
// Checker for the timer and power control register group.
// Assumes it is bound to ctp_regs and sees only its ports.
`default_nettype none
module ctp_regs_sva (
    // Clock, reset and register port
    input wire logic i_clock, i_rst, i_wr, i_rd,
    input wire logic [7:0] i_addr, i_wdata, o_rdata,
    // Timer0, ext0 and power control side
    input wire logic i_timer0_overflow, i_ack_timer0, i_timer0_pin_gating, i_ext0_pin,
    input wire logic o_baud_doubler, o_stop_mode, o_idle_mode,
    input wire logic o_timer0_count_en, o_timer0_request
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire logic pcw = i_wr && i_addr == ctp_pkg::ADDR_POWER_CONTROL;
    wire logic tcw = i_wr && i_addr == ctp_pkg::ADDR_TIMER_INTERRUPT_CONTROL;
    // ==========================================
    // Register storage and power modes
    sequence s_scr_wr;
        i_wr && i_addr == ctp_pkg::ADDR_SCRATCH;
    endsequence
    sequence s_scr_rd;
        i_rd && i_addr == ctp_pkg::ADDR_SCRATCH;
    endsequence
    a_scratch_read_back: assert property (s_scr_wr ##1 s_scr_rd |=>
        o_rdata == $past(i_wdata, 2)) else $error("scratch read back differs");
    a_baud_bit_write: assert property (pcw |=> o_baud_doubler == $past(i_wdata[7]))
        else $error("baud doubler not written");
    a_stop_mode_entry: assert property (pcw && i_wdata[1] |=> o_stop_mode)
        else $error("stop mode not entered");
    a_idle_mode_entry: assert property (pcw && i_wdata[1:0] == 2'b01 |=>
        o_idle_mode && !o_stop_mode) else $error("idle mode not entered");
    // ==========================================
    // Timer0 flag and counting
    a_overflow_sets_flag: assert property (i_timer0_overflow |=> o_timer0_request)
        else $error("overflow flag not set");
    a_vector_clears_flag: assert property (i_ack_timer0 && !i_timer0_overflow && !tcw
        |=> !o_timer0_request) else $error("overflow flag not cleared");
    a_gate_stops_count: assert property (!i_ext0_pin ##2 i_timer0_pin_gating
        |-> !o_timer0_count_en) else $error("gated timer counts");
    a_run_bit_count: assert property (tcw && !i_timer0_pin_gating ##1 !i_timer0_pin_gating
        |-> o_timer0_count_en == $past(i_wdata[4])) else $error("run bit ignored");
endmodule
bind ctp_regs ctp_regs_sva u_ctp_regs_sva (.i_clock, .i_rst, .i_wr, .i_rd, .i_addr,
    .i_wdata, .o_rdata, .i_timer0_overflow, .i_ack_timer0, .i_timer0_pin_gating,
    .i_ext0_pin, .o_baud_doubler, .o_stop_mode, .o_idle_mode, .o_timer0_count_en,
    .o_timer0_request);
`default_nettype wire

// ==== verification/testbench.sv ====
// Bench for the timer and power control register group.
// Assumes the core model answers vector requests while take is high.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Signals
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    ctp_pkg::ctp_bus_s bus = '0;
    logic ovf0 = 1'b0, ovf1 = 1'b0, timer0_pin_gating = 1'b0, timer1_pin_gating = 1'b0;
    logic pin0 = 1'b1, pin1 = 1'b1, take = 1'b0;
    logic [7:0] rdata, sp;
    logic [15:0] dp;
    logic baud, stop, idle, cnt0, cnt1, xr0, xr1, tr0, tr1, irq;
    ctp_pkg::ctp_ack_s ack;
    int miscompares = 0;
    int checked = 0;
    logic [7:0] adr [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'ha5};
    logic [7:0] rst [7] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    ctp_regs u_ctp_regs (.i_clock(i_clock), .i_rst(i_rst), .i_addr(bus.addr),
        .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .o_rdata(rdata),
        .i_timer0_overflow(ovf0), .i_timer1_overflow(ovf1), .i_timer0_pin_gating(timer0_pin_gating),
        .i_timer1_pin_gating(timer1_pin_gating), .i_ack_timer0(ack.tmr0), .i_ack_timer1(ack.tmr1),
        .i_ack_ext0(ack.ext0), .i_ack_ext1(ack.ext1), .i_ext0_pin(pin0), .i_ext1_pin(pin1),
        .o_stack_pointer(sp), .o_data_pointer(dp), .o_baud_doubler(baud),
        .o_stop_mode(stop), .o_idle_mode(idle), .o_timer0_count_en(cnt0),
        .o_timer1_count_en(cnt1), .o_ext0_request(xr0), .o_ext1_request(xr1),
        .o_timer0_request(tr0), .o_timer1_request(tr1), .o_irq(irq));
    ctp_core_model u_ctp_core_model (.i_clock(i_clock), .i_rst(i_rst), .i_take(take),
        .i_req({tr1, tr0, xr1, xr0}), .o_ack(ack));
    // ==========================================
    // Tasks: wr, rd, nop and vector each start and end just after a rising edge
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Write strobe stays up so writes can follow with no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus.rd <= 1'b0;
        @(negedge i_clock);
        chk(rdata, exp);
        @(posedge i_clock);
    endtask
    task automatic nop(input int n);
        bus.wr <= 1'b0;
        repeat (n) @(posedge i_clock);
    endtask
    task automatic vector();
        take <= 1'b1;
        for (int i = 0; i <= 8; i++) begin
            @(negedge i_clock);
            if (ack != '0) break;
            if (i == 8) begin
                miscompares++;
                end_of_test();
            end
        end
        @(posedge i_clock);
        take <= 1'b0;
        nop(2);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        foreach (adr[i]) rd(adr[i], rst[i]);
        wr(8'h82, 8'h3c);
        wr(8'h83, 8'hc3);
        wr(8'h81, 8'h5a);
        wr(8'h80, 8'ha5);
        rd(8'h80, 8'ha5);
        chk({sp, dp}, 24'h5ac33c);
        wr(8'h87, 8'hff);
        rd(8'h87, 8'h8f);
        chk({baud, stop, idle}, 3'b110);
        wr(8'h87, 8'h01);
        rd(8'h87, 8'h01);
        chk({baud, stop, idle}, 3'b001);
        wr(8'h88, 8'h50);
        nop(2);
        chk({cnt1, cnt0}, 2'b11);
        timer0_pin_gating <= 1'b1;
        timer1_pin_gating <= 1'b1;
        pin0 <= 1'b0;
        nop(4);
        chk({cnt1, cnt0, xr0}, 3'b101);
        timer0_pin_gating <= 1'b0;
        timer1_pin_gating <= 1'b0;
        wr(8'h88, 8'h05);
        pin0 <= 1'b1;
        nop(4);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        nop(4);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        nop(4);
        rd(8'h88, 8'h0f);
        rd(8'hc0, 8'h0c);
        vector();
        rd(8'h88, 8'h05);
        wr(8'h88, 8'h00);
        pin1 <= 1'b0;
        nop(4);
        chk({xr1, xr0}, 2'b10);
        wr(8'hc2, 8'h0f);
        wr(8'hc1, 8'h03);
        ovf0 <= 1'b1;
        ovf1 <= 1'b1;
        nop(1);
        ovf0 <= 1'b0;
        ovf1 <= 1'b0;
        pin1 <= 1'b1;
        nop(3);
        chk({tr1, tr0, irq, xr1}, 4'b1110);
        rd(8'hc0, 8'h03);
        wr(8'hc2, 8'h03);
        nop(2);
        chk({tr1, tr0, irq}, 3'b110);
        vector();
        chk({tr1, tr0}, 2'b00);
        wr(8'h88, 8'h20);
        nop(2);
        chk({tr0, irq}, 2'b10);
        wr(8'h88, 8'h00);
        nop(2);
        chk(tr0, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
